// >>> dcd_map.svh
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH
// command bytes
`define DCD_CMD_REV 8'h00
`define DCD_CMD_STAT 8'h02
`define DCD_CMD_RUNTIME 8'h03
`define DCD_CMD_WR_CTL 8'h04
`define DCD_CMD_RD_CTL 8'h05
`define DCD_CMD_WR_PC 8'h06
`define DCD_CMD_RD_PC 8'h07
`define DCD_CMD_WR_REG 8'h08
`define DCD_CMD_RD_REG 8'h09
`define DCD_CMD_WR_PMEM 8'h0A
`define DCD_CMD_RD_PMEM 8'h0B
`define DCD_CMD_WR_DMEM 8'h0C
`define DCD_CMD_RD_DMEM 8'h0D
`define DCD_CMD_CRC 8'h0E
`define DCD_CMD_STEP 8'h10
`define DCD_CMD_STUFF 8'h11
`define DCD_CMD_EXEC 8'h12
// control register fields
`define DCD_CTL_MODE_BIT 7
`define DCD_CTL_WMASK 8'hE1
`define DCD_CTL_RESET 8'h00
// status register fields
`define DCD_STAT_DBG_BIT 7
`define DCD_STAT_HALT_BIT 6
`define DCD_STAT_FRPENB_BIT 5
// fixed values
`define DCD_VERSION_MAJOR 8'h01
`define DCD_VERSION_MINOR 8'h00
`define DCD_FILL_BYTE 8'hFF
`define DCD_RUNTIME_MAX 16'hFFFF
`define DCD_RUNTIME_RESET 16'h0000
`define DCD_FLASH_REG_HI 4'hF
`define DCD_FLASH_REG_LO_BASE 8'hF8
`define DCD_FLASH_CTL_ADDR 12'hFF8
`define DCD_MASS_ERASE 8'h63
`endif

// >>> dcd_pkg.sv
package dcd_pkg;
  typedef enum logic [3:0] {
    DCD_IDLE = 4'h0,
    DCD_PARAM = 4'h1,
    DCD_SIZE = 4'h2,
    DCD_WDATA = 4'h3,
    DCD_RDATA = 4'h4,
    DCD_TX1 = 4'h5,
    DCD_TX2 = 4'h6,
    DCD_WAITTX = 4'h7
  } dcd_state_t;
endpackage : dcd_pkg

// >>> dcd_tx_if.sv
interface dcd_tx_if;
  logic [7:0] data;
  logic valid;
  logic busy;
  modport src (output data, output valid, input busy);
  modport dst (input data, input valid, output busy);
endinterface : dcd_tx_if

// >>> dcd_runtime.sv
`include "dcd_map.svh"
module dcd_runtime (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic run_in,
  input wire logic clear_in,
  // count
  output logic [15:0] count_out
);
  // counts cycles outside debug mode, stops at the top value
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || clear_in) begin
      count_out <= `DCD_RUNTIME_RESET;
    end else if (run_in && count_out != `DCD_RUNTIME_MAX) begin
      count_out <= count_out + 16'h0001;
    end
  end
endmodule : dcd_runtime

// >>> dcd_tx_hold.sv
module dcd_tx_hold (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // from decoder
  dcd_tx_if.dst tx,
  // to serial transmitter
  output logic [7:0] byte_out,
  output logic byte_valid_out,
  input wire logic byte_ready_in
);
  // single holding byte: decoder waits on busy, so nothing is lost
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      byte_valid_out <= 1'b0;
      byte_out <= 8'h00;
    end else if (tx.valid && !byte_valid_out) begin
      byte_valid_out <= 1'b1;
      byte_out <= tx.data;
    end else if (byte_valid_out && byte_ready_in) begin
      byte_valid_out <= 1'b0;
    end
  end
  assign tx.busy = byte_valid_out;
endmodule : dcd_tx_hold

// >>> dcd_decoder.sv
`include "dcd_map.svh"
// What this block does
// - outside debug mode only revision, status, control write, control read and register write run
// - command 00H returns version major byte then minor byte
// - command 02H returns the debug status register byte
// - runtime count from zero per clock outside debug mode, saturating, sent high byte first on 03H
// - runtime count cleared whenever register write or register read commands run
// - command 04H loads the following byte into the control register with bits 4 to 1 cleared
// - under read protection control writes may set but never clear debug mode
// - command 05H returns the control register byte
// - command 06H takes two pc bytes in debug mode only, dropped under protection
// - command 07H returns pc high then low, FFFFH when blocked
// - register write framed as address high, address low, size, data; size 0 is 256
// - register write outside debug mode consumes and ignores address and data
// - under protection register writes reach only flash control registers
// - under protection only mass erase may be written to flash control
// - register read same framing, returns FFH bytes when blocked
// - under protection pc writes do nothing, pc and register reads give FFH bytes; memory and instruction commands never run
// - debug mode follows control bit seven and halts the processor
module dcd_decoder (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // received bytes from serial receiver
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  // bytes to serial transmitter
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  // device state
  input wire logic read_protect_option_in,
  input wire logic read_protect_enb_in,
  input wire logic halt_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] reg_rdata_in,
  // debug control
  output logic debug_mode_out,
  output logic [7:0] debug_control_reg_out,
  output logic cpu_stop_out,
  // pc write
  output logic pc_we_out,
  output logic [15:0] pc_wdata_out,
  // register file port
  output logic reg_we_out,
  output logic [11:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  dcd_pkg::dcd_state_t state;
  logic [7:0] cmd;
  logic [7:0] ctl;
  logic [1:0] pidx;
  logic [7:0] phi;
  logic [11:0] addr;
  logic [8:0] remain;
  logic [7:0] second;
  logic rd_pend;
  logic go_ok;
  logic prot;
  logic blocked;
  logic clr_rt;
  logic [15:0] rt_count;
  logic [7:0] stat;
  logic [7:0] next_ctl;
  logic tx_go;
  logic [7:0] tx_data;
  logic [7:0] op_byte;
  logic param_last;
  logic next_reg_we;
  dcd_tx_if txi ();

  assign prot = read_protect_option_in;
  assign blocked = !ctl[`DCD_CTL_MODE_BIT] || prot;
  assign stat = {ctl[`DCD_CTL_MODE_BIT], halt_in, read_protect_enb_in, 5'h00};
  assign param_last = (pidx == 2'd1);

  // runtime counter runs only while not in debug mode
  dcd_runtime u_rt (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(!ctl[`DCD_CTL_MODE_BIT]),
    .clear_in(clr_rt),
    .count_out(rt_count)
  );

  // one-byte hold toward the transmitter; it owns the outputs
  dcd_tx_hold u_tx (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tx(txi),
    .byte_out(tx_byte_out),
    .byte_valid_out(tx_valid_out),
    .byte_ready_in(tx_ready_in)
  );
  assign txi.data = tx_data;
  assign txi.valid = tx_go;

  // command gate: which first bytes are accepted in the present mode
  always_comb begin
    case (rx_byte_in)
      `DCD_CMD_REV, `DCD_CMD_STAT, `DCD_CMD_WR_CTL, `DCD_CMD_RD_CTL: go_ok = 1'b1;
      `DCD_CMD_RUNTIME, `DCD_CMD_WR_PC, `DCD_CMD_RD_PC, `DCD_CMD_WR_REG,
      `DCD_CMD_RD_REG: go_ok = ctl[`DCD_CTL_MODE_BIT] || rx_byte_in == `DCD_CMD_WR_REG;
      default: go_ok = 1'b0;
    endcase
  end

  // control register write with protection keeping debug mode set
  always_comb begin
    next_ctl = rx_byte_in & `DCD_CTL_WMASK;
    if (prot && ctl[`DCD_CTL_MODE_BIT]) begin
      next_ctl[`DCD_CTL_MODE_BIT] = 1'b1;
    end
  end

  // register file byte write only when allowed
  always_comb begin
    op_byte = rx_byte_in;
    next_reg_we = 1'b0;
    if (state == dcd_pkg::DCD_WDATA && rx_valid_in && ctl[`DCD_CTL_MODE_BIT]) begin
      if (!prot) begin
        next_reg_we = 1'b1;
      end else if (addr[11:8] == `DCD_FLASH_REG_HI && addr[7:3] == 5'h1F) begin
        next_reg_we = (addr != `DCD_FLASH_CTL_ADDR) || (rx_byte_in == `DCD_MASS_ERASE);
      end
    end
  end

  // register port from flops; strobe, address and data stay aligned
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_we_out <= 1'b0;
      reg_addr_out <= 12'h000;
      reg_wdata_out <= 8'h00;
    end else begin
      reg_we_out <= next_reg_we;
      reg_addr_out <= addr;
      reg_wdata_out <= op_byte;
    end
  end

  // main sequencer: parameter framing then answer
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= dcd_pkg::DCD_IDLE;
      cmd <= 8'h00;
      pidx <= 2'd0;
      phi <= 8'h00;
      addr <= 12'h000;
      remain <= 9'h000;
      rd_pend <= 1'b0;
    end else begin
      case (state)
        dcd_pkg::DCD_IDLE: begin
          if (rx_valid_in && go_ok) begin
            cmd <= rx_byte_in;
            pidx <= 2'd0;
            case (rx_byte_in)
              `DCD_CMD_WR_CTL, `DCD_CMD_WR_PC, `DCD_CMD_WR_REG,
              `DCD_CMD_RD_REG: state <= dcd_pkg::DCD_PARAM;
              default: state <= dcd_pkg::DCD_TX1;
            endcase
          end
        end
        dcd_pkg::DCD_PARAM: begin
          if (rx_valid_in) begin
            pidx <= pidx + 2'd1;
            phi <= rx_byte_in;
            if (cmd == `DCD_CMD_WR_CTL) begin
              state <= dcd_pkg::DCD_IDLE;
            end else if (cmd == `DCD_CMD_WR_PC && param_last) begin
              state <= dcd_pkg::DCD_IDLE;
            end else if (param_last) begin
              addr <= {phi[3:0], rx_byte_in};
              state <= dcd_pkg::DCD_SIZE;
            end
          end
        end
        dcd_pkg::DCD_SIZE: begin
          if (rx_valid_in) begin
            remain <= (rx_byte_in == 8'h00) ? 9'h100 : {1'b0, rx_byte_in};
            state <= (cmd == `DCD_CMD_WR_REG) ? dcd_pkg::DCD_WDATA : dcd_pkg::DCD_RDATA;
          end
        end
        dcd_pkg::DCD_WDATA: begin
          if (rx_valid_in) begin
            remain <= remain - 9'h001;
            addr <= addr + 12'h001;
            if (remain == 9'h001) begin
              state <= dcd_pkg::DCD_IDLE;
            end
          end
        end
        dcd_pkg::DCD_RDATA: begin
          // read data of the addressed byte is valid the cycle after the address
          if (!txi.busy && !rd_pend) begin
            rd_pend <= 1'b1;
          end else if (tx_go) begin
            rd_pend <= 1'b0;
            remain <= remain - 9'h001;
            addr <= addr + 12'h001;
            if (remain == 9'h001) begin
              state <= dcd_pkg::DCD_IDLE;
            end
          end
        end
        dcd_pkg::DCD_TX1: begin
          if (tx_go) begin
            state <= (cmd == `DCD_CMD_STAT || cmd == `DCD_CMD_RD_CTL) ? dcd_pkg::DCD_IDLE : dcd_pkg::DCD_TX2;
          end
        end
        dcd_pkg::DCD_TX2: begin
          if (tx_go) begin
            state <= dcd_pkg::DCD_IDLE;
          end
        end
        default: state <= dcd_pkg::DCD_IDLE;
      endcase
    end
  end

  // response byte selection and strobe toward the hold stage
  always_comb begin
    tx_go = 1'b0;
    tx_data = `DCD_FILL_BYTE;
    second = 8'h00;
    case (cmd)
      `DCD_CMD_REV: begin
        tx_data = (state == dcd_pkg::DCD_TX1) ? `DCD_VERSION_MAJOR : `DCD_VERSION_MINOR;
      end
      `DCD_CMD_STAT: tx_data = stat;
      `DCD_CMD_RUNTIME: tx_data = (state == dcd_pkg::DCD_TX1) ? rt_count[15:8] : rt_count[7:0];
      `DCD_CMD_RD_CTL: tx_data = ctl;
      `DCD_CMD_RD_PC: begin
        second = blocked ? `DCD_FILL_BYTE : pc_in[7:0];
        tx_data = (state == dcd_pkg::DCD_TX1) ? (blocked ? `DCD_FILL_BYTE : pc_in[15:8]) : second;
      end
      `DCD_CMD_RD_REG: tx_data = blocked ? `DCD_FILL_BYTE : reg_rdata_in;
      default: tx_data = `DCD_FILL_BYTE;
    endcase
    if (!txi.busy) begin
      tx_go = (state == dcd_pkg::DCD_TX1) || (state == dcd_pkg::DCD_TX2) ||
              (state == dcd_pkg::DCD_RDATA && rd_pend);
    end
  end

  // runtime clear when register commands run
  always_comb begin
    clr_rt = 1'b0;
    if (state == dcd_pkg::DCD_IDLE && rx_valid_in && go_ok &&
        (rx_byte_in == `DCD_CMD_WR_REG || rx_byte_in == `DCD_CMD_RD_REG)) begin
      clr_rt = 1'b1;
    end
  end

  // debug control register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctl <= `DCD_CTL_RESET;
    end else if (state == dcd_pkg::DCD_PARAM && cmd == `DCD_CMD_WR_CTL && rx_valid_in) begin
      ctl <= next_ctl;
    end
  end

  // program counter write, only in debug mode without protection
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pc_we_out <= 1'b0;
      pc_wdata_out <= 16'h0000;
    end else begin
      pc_we_out <= 1'b0;
      if (state == dcd_pkg::DCD_PARAM && cmd == `DCD_CMD_WR_PC && rx_valid_in && param_last) begin
        if (!blocked) begin
          pc_wdata_out <= {phi, rx_byte_in};
        end
        pc_we_out <= !blocked;
      end
    end
  end

  // mirrored mode outputs for the processor
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      debug_mode_out <= 1'b0;
      cpu_stop_out <= 1'b0;
      debug_control_reg_out <= `DCD_CTL_RESET;
    end else begin
      debug_mode_out <= ctl[`DCD_CTL_MODE_BIT];
      cpu_stop_out <= ctl[`DCD_CTL_MODE_BIT];
      debug_control_reg_out <= ctl;
    end
  end
endmodule : dcd_decoder

// >>> dcd_decoder_assertions.sv
`include "dcd_map.svh"
module dcd_decoder_assertions (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic read_protect_option_in,
  input wire logic debug_mode_out,
  input wire logic [7:0] debug_control_reg_out,
  input wire logic cpu_stop_out,
  input wire logic pc_we_out,
  input wire logic reg_we_out,
  input wire logic [11:0] reg_addr_out,
  input wire logic [7:0] reg_wdata_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // mode and processor stop follow control bit seven
  AST_MODE_BIT: assert property (debug_mode_out == debug_control_reg_out[`DCD_CTL_MODE_BIT])
    else $error("debug mode differs from control bit");
  AST_CPU_STOP: assert property (cpu_stop_out == debug_mode_out)
    else $error("cpu stop differs from debug mode");
  // a pending byte may not move before the transmitter takes it
  AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
    else $error("response byte dropped or changed while pending");
  AST_NO_CLEAR: assert property (read_protect_option_in && debug_mode_out |=> debug_mode_out)
    else $error("debug mode cleared under protection");
  AST_PC_GATE: assert property (pc_we_out |-> debug_mode_out && !read_protect_option_in)
    else $error("pc written while blocked");
  AST_PC_PULSE: assert property (pc_we_out |=> !pc_we_out)
    else $error("pc write longer than one cycle");
  AST_REG_DBG: assert property (reg_we_out |-> debug_mode_out)
    else $error("register written outside debug mode");
  AST_REG_FLASH: assert property (reg_we_out && read_protect_option_in |-> reg_addr_out[11:3] == 9'h1FF)
    else $error("protected write outside flash control");
  AST_ERASE: assert property (reg_we_out && read_protect_option_in && reg_addr_out == 12'hFF8
    |-> reg_wdata_out == `DCD_MASS_ERASE)
    else $error("protected flash command not mass erase");
  AST_CTL_RSV: assert property (debug_control_reg_out[4:1] == 4'h0)
    else $error("reserved control bits set");
endmodule : dcd_decoder_assertions
bind dcd_decoder dcd_decoder_assertions u_dcd_decoder_assertions (.sys_clk_in, .rst_n_in, .tx_byte_out,
  .tx_valid_out, .tx_ready_in, .read_protect_option_in, .debug_mode_out, .debug_control_reg_out,
  .cpu_stop_out, .pc_we_out, .reg_we_out, .reg_addr_out, .reg_wdata_out);

// >>> dcd_tx_sink.sv
module dcd_tx_sink (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // pacing
  input wire logic slow_in,
  // decoder side
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // collected bytes
  output logic got_out,
  output logic [7:0] got_byte_out
);
  logic [1:0] pace;
  // slow mode takes one byte in four cycles, like a busy shifter
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
    end
  end
  assign tx_ready_out = !slow_in || (pace == 2'h3);
  // a byte counts only when offered and taken together
  assign got_out = tx_valid_in && tx_ready_out;
  assign got_byte_out = tx_byte_in;
endmodule : dcd_tx_sink

// >>> dcd_decoder_tb_top.sv
module dcd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [47:0] b; logic [2:0] n; logic [1:0] nr; logic [15:0] e;} dcd_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_valid = 1'b0;
  logic prot = 1'b0;
  logic slow = 1'b0;
  logic [7:0] tx_byte, ctl, wdata, got_byte, rdata, last_d;
  logic tx_valid, tx_ready, dmode, stop, pc_we, reg_we, got;
  logic [15:0] pc_wdata, resp, first;
  logic [11:0] addr, last_a;
  logic [7:0] rq[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int we_cnt = 0;
  int free_cnt = 0;
  int we0;
  // ordinary commands: bytes sent, count, answers, expected answer
  dcd_row_t rows[10] = '{
    '{48'h000000000000, 3'd1, 2'd2, 16'h0100}, '{48'h020000000000, 3'd1, 2'd1, 16'h0060},
    '{48'h050000000000, 3'd1, 2'd1, 16'h0000}, '{48'h070000000000, 3'd1, 2'd0, 16'h0000},
    '{48'h049E00000000, 3'd2, 2'd0, 16'h0000}, '{48'h050000000000, 3'd1, 2'd1, 16'h0080},
    '{48'h020000000000, 3'd1, 2'd1, 16'h00E0}, '{48'h04C000000000, 3'd2, 2'd0, 16'h0000},
    '{48'h050000000000, 3'd1, 2'd1, 16'h00C0}, '{48'h070000000000, 3'd1, 2'd2, 16'h1234}};
  // register file answers with a pattern of its address
  assign rdata = addr[7:0] ^ 8'h5A;
  dcd_decoder u_dcd_decoder (.sys_clk_in(clk), .rst_n_in(rst_n), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .read_protect_option_in(prot),
    .read_protect_enb_in(1'b1), .halt_in(1'b1), .pc_in(16'h1234), .reg_rdata_in(rdata),
    .debug_mode_out(dmode), .debug_control_reg_out(ctl), .cpu_stop_out(stop), .pc_we_out(pc_we),
    .pc_wdata_out(pc_wdata), .reg_we_out(reg_we), .reg_addr_out(addr), .reg_wdata_out(wdata));
  dcd_tx_sink u_dcd_tx_sink (.sys_clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .tx_byte_in(tx_byte),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .got_out(got), .got_byte_out(got_byte));
  initial begin
    forever #5 clk = ~clk;
  end
  // collect answers, register writes and cycles spent out of debug mode
  always @(posedge clk) begin
    if (got === 1'b1) rq.push_back(got_byte);
    if (reg_we === 1'b1) begin
      we_cnt++;
      last_a = addr;
      last_d = wdata;
    end
    if (dmode === 1'b0) free_cnt++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1 rx_byte = b;
    rx_valid = 1'b1;
    @(posedge clk);
    #1 rx_valid = 1'b0;
  endtask : send
  // host waits for every answer before the next command, half duplex
  task automatic run(input logic [47:0] b, input int n, input int nr);
    rq.delete();
    resp = 16'h0000;
    for (int i = 0; i < n; i++) send(b[47-8*i -: 8]);
    for (int k = 0; k < 300 && rq.size() < nr; k++) @(posedge clk);
    repeat (20) @(posedge clk);
    #1;
    chk(16'(rq.size()), 16'(nr));
    foreach (rq[i]) resp = {resp[7:0], rq[i]};
  endtask : run
  task automatic do_reset();
    #1;
    rst_n = 1'b0;
    prot = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({ctl, tx_valid, dmode, stop, pc_we, reg_we, 3'h0}, 16'h0000);
    $display("test reset done");
  endtask : do_reset
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    #200us;
    error_cnt++;
    close_out();
  end
  initial begin
    do_reset();
    run(48'h010000000000, 1, 0);
    // a write outside debug swallows its data byte 00 without answering
    run(48'h080000010000, 5, 0);
    chk(16'(we_cnt), 16'h0000);
    slow = 1'b1;
    foreach (rows[i]) begin
      run(rows[i].b, rows[i].n, rows[i].nr);
      chk(resp, rows[i].e);
    end
    $display("test table done");
    slow = 1'b0;
    run(48'h06ABCD000000, 3, 0);
    chk(pc_wdata, 16'hABCD);
    run(48'h080F1202AABB, 6, 0);
    chk({4'h0, last_a}, 16'h0F13);
    chk({8'h00, last_d}, 16'h00BB);
    chk(16'(we_cnt), 16'h0002);
    run(48'h090F12010000, 4, 1);
    chk(resp, 16'h0048);
    run(48'h030000000000, 1, 2);
    chk(resp, 16'h0000);
    free_cnt = 0;
    run(48'h040000000000, 2, 0);
    repeat (100) @(posedge clk);
    run(48'h048000000000, 2, 0);
    run(48'h030000000000, 1, 2);
    first = resp;
    run(48'h030000000000, 1, 2);
    chk(resp, first);
    chk(16'(first > 16'd100 && first <= 16'(free_cnt + 2)), 16'h0001);
    $display("test debug done");
    prot = 1'b1;
    run(48'h070000000000, 1, 2);
    chk(resp, 16'hFFFF);
    run(48'h090F12010000, 4, 1);
    chk(resp, 16'h00FF);
    we0 = we_cnt;
    run(48'h080FF8016300, 5, 0);
    run(48'h080FF8011100, 5, 0);
    run(48'h080010015500, 5, 0);
    chk(16'(we_cnt - we0), 16'h0001);
    chk({4'h0, last_a}, 16'h0FF8);
    chk({8'h00, last_d}, 16'h0063);
    run(48'h061122000000, 3, 0);
    chk(pc_wdata, 16'hABCD);
    run(48'h040000000000, 2, 0);
    run(48'h050000000000, 1, 1);
    chk(resp, 16'h0080);
    $display("test protect done");
    do_reset();
    close_out();
  end
endmodule : dcd_decoder_tb_top
